// ---- common/ordc_consts.svh ----
// Purpose: shared constants of the octal relay driver control
// Assumes: included by bare name, once per compile unit
// Notes: reset values and widths only; no register map exists
//
// Overview of operation
// RQ1 - serial variant holds an 8-bit shift register copied to latch on chip select rise
// RQ2 - shift bit n drives channel n+1; bit 7 drives channel 8, bit 0 channel 1
// RQ3 - while chip select low, serial input is sampled on each shift clock rise
// RQ4 - chip select low-to-high copies the shift register, all eight outputs change together
// RQ5 - chain output shows last shift stage and changes on shift clock fall
// RQ6 - chain output is the serial input delayed by eight shift clock cycles
// RQ7 - bit 7 goes in first and comes out first on the chain output
// RQ8 - set input low forces every latch and register to one, all outputs on
// RQ9 - asserted set overrides all serial and parallel interface activity
// RQ10 - with reset and set both asserted, reset always wins
// RQ11 - parallel variant: level high turns addressed output on, low turns it off
// RQ12 - three address bits pick one output; address and level latched on chip select rise
// RQ13 - reset input low clears all latches and registers, all outputs off
// RQ14 - shifting more or fewer than eight bits keeps only the latest eight
// RQ15 - with chip select high, serial input and shift clock change nothing
// RQ16 - with chip select high, address and level inputs change nothing
// RQ17 - address value plus one selects the channel, bit 2 most significant
// RQ18 - each channel pulls low open-drain when its latch bit is one, else floats
`ifndef ORDC_CONSTS_SVH
`define ORDC_CONSTS_SVH
`define ORDC_CHAN_COUNT 8
`define ORDC_ADDR_WIDTH 3
`define ORDC_SYNC_STAGES 3
`define ORDC_ALL_OFF 8'h00
`define ORDC_ALL_ON 8'hff
`define ORDC_DRAIN_LEVEL 8'h00
`define ORDC_PIN_IDLE 9'h103
`endif

// ---- common/ordc_pkg.sv ----
// Purpose: types of the octal relay driver control
// Assumes: ordc_consts.svh on the include path
// Notes: pin bundle and open-drain coil bundle
`include "ordc_consts.svh"
package ordc_pkg;
	typedef enum logic {ORDC_SERIAL, ORDC_PARALLEL} ordc_variant_type;
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic din;
		logic level_select;
		logic addr_bit2;
		logic addr_bit1;
		logic addr_bit0;
		logic set_n;
		logic reset_n;
	} ordc_pins_type;
	typedef struct packed {
		logic [`ORDC_CHAN_COUNT-1:0] out;
		logic [`ORDC_CHAN_COUNT-1:0] oe;
	} ordc_coil_type;
endpackage

// ---- rtl/ordc_sync.sv ----
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: sys_clk domain, synchronous active-high reset
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ns
module ordc_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] filt
);
	// ==========================================
	// per-bit stages
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic s1, s2, s3, f;
			logic next_f;
			always_comb begin
				next_f = (s2 == s3) ? s3 : f;
			end
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					s1 <= RESET_VALUE[i];
					s2 <= RESET_VALUE[i];
					s3 <= RESET_VALUE[i];
					f <= RESET_VALUE[i];
				end else if (ce) begin
					s1 <= async_in[i];
					s2 <= s1;
					s3 <= s2;
					f <= next_f;
				end
			end
			assign filt[i] = f;
		end
	endgenerate
endmodule // ordc_sync

// ---- rtl/ordc_top.sv ----
// Purpose: control logic of an eight-channel relay driver
// Assumes: all pins asynchronous to sys_clk (10 MHz); shift clock well below it
// Notes: serial or parallel variant chosen by the variant input
`timescale 1ns/1ns
`include "ordc_consts.svh"
module ordc_top (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire ordc_pkg::ordc_variant_type variant,
	input wire ordc_pkg::ordc_pins_type pins,
	output ordc_pkg::ordc_coil_type coil,
	output logic chain_out
);
	import ordc_pkg::*;

	// ==========================================
	// pin synchronisation
	ordc_pins_type pins_f;
	ordc_pins_type pins_prev;
	ordc_pins_type next_pins_prev;
	logic [$bits(ordc_pins_type)-1:0] filt_vec;

	ordc_sync #(
		.WIDTH($bits(ordc_pins_type)),
		.RESET_VALUE(`ORDC_PIN_IDLE)
	) u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.ce(ce),
		.async_in(pins),
		.filt(filt_vec)
	);

	assign pins_f = ordc_pins_type'(filt_vec);

	// ==========================================
	// edge and priority decode
	logic cs_rise;
	logic sclk_rise;
	logic sclk_fall;
	logic clear_all;
	logic set_all;
	logic normal;
	logic serial_mode;
	logic selected;
	logic [`ORDC_ADDR_WIDTH-1:0] addr;

	always_comb begin
		cs_rise = !pins_prev.cs_n && pins_f.cs_n;
		sclk_rise = !pins_prev.sclk && pins_f.sclk;
		sclk_fall = pins_prev.sclk && !pins_f.sclk;
		clear_all = !pins_f.reset_n; // RQ13
		set_all = pins_f.reset_n && !pins_f.set_n; // RQ10
		normal = pins_f.reset_n && pins_f.set_n;
		serial_mode = (variant == ORDC_SERIAL);
		selected = !pins_f.cs_n; // RQ15 RQ16
		addr = {pins_f.addr_bit2, pins_f.addr_bit1, pins_f.addr_bit0}; // RQ17
	end

	// ==========================================
	// shift register, latch and chain output
	logic [`ORDC_CHAN_COUNT-1:0] shift_reg;
	logic [`ORDC_CHAN_COUNT-1:0] next_shift;
	logic [`ORDC_CHAN_COUNT-1:0] next_latch;
	logic [`ORDC_CHAN_COUNT-1:0] next_drain;
	logic next_chain;

	always_comb begin
		next_shift = shift_reg;
		next_latch = coil.oe;
		next_chain = chain_out;
		next_drain = `ORDC_DRAIN_LEVEL; // RQ18
		next_pins_prev = pins_f;
		if (clear_all) begin
			next_shift = `ORDC_ALL_OFF; // RQ13
			next_latch = `ORDC_ALL_OFF; // RQ10
			next_chain = 1'b0;
		end else if (set_all) begin
			next_shift = `ORDC_ALL_ON; // RQ8
			next_latch = `ORDC_ALL_ON; // RQ9
			next_chain = 1'b1;
		end else if (serial_mode) begin
			if (selected && sclk_rise) begin
				next_shift = {shift_reg[`ORDC_CHAN_COUNT-2:0], pins_f.din}; // RQ3 RQ7 RQ14
			end
			if (selected && sclk_fall) begin
				next_chain = shift_reg[`ORDC_CHAN_COUNT-1]; // RQ5 RQ6 RQ7
			end
			if (cs_rise) begin
				next_latch = shift_reg; // RQ1 RQ2 RQ4
			end
		end else begin
			if (cs_rise) begin
				next_latch[addr] = pins_f.level_select; // RQ11 RQ12
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pins_prev <= ordc_pins_type'(`ORDC_PIN_IDLE);
			shift_reg <= `ORDC_ALL_OFF;
			coil.oe <= `ORDC_ALL_OFF;
			coil.out <= `ORDC_DRAIN_LEVEL;
			chain_out <= 1'b0;
		end else if (ce) begin
			pins_prev <= next_pins_prev;
			shift_reg <= next_shift;
			coil.oe <= next_latch; // RQ18
			coil.out <= next_drain;
			chain_out <= next_chain;
		end
	end

	// ==========================================
	// checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	sequence s_normal_step;
		ce && normal;
	endsequence

	sequence s_serial_latch;
		s_normal_step ##0 serial_mode && cs_rise;
	endsequence

	sequence s_parallel_latch;
		s_normal_step ##0 !serial_mode && cs_rise;
	endsequence

	sequence s_serial_shift;
		s_normal_step ##0 serial_mode && selected && sclk_rise;
	endsequence

	sequence s_clear_step;
		ce && clear_all;
	endsequence

	sequence s_set_step;
		ce && set_all;
	endsequence

	a_shift_on_rise: assert property ( // RQ3
		s_serial_shift |=> shift_reg == {$past(shift_reg[`ORDC_CHAN_COUNT-2:0]), $past(pins_f.din)})
		else $error("shift register missed a rising shift clock");

	a_latch_copy: assert property ( // RQ4
		s_serial_latch |=> coil.oe == $past(shift_reg))
		else $error("latch did not take the shift register on chip select rise");

	a_chain_on_fall: assert property ( // RQ5
		s_normal_step ##0 serial_mode && selected && sclk_fall |=> chain_out == $past(shift_reg[7]))
		else $error("chain output did not follow the last stage on falling shift clock");

	a_chain_quiet: assert property ( // RQ5
		ce && normal && !sclk_fall |=> $stable(chain_out))
		else $error("chain output moved without a falling shift clock");

	a_clear_wins: assert property ( // RQ10
		ce && !pins_f.reset_n |=> coil.oe == `ORDC_ALL_OFF && shift_reg == `ORDC_ALL_OFF && !chain_out)
		else $error("reset input did not clear every register");

	a_set_all_on: assert property ( // RQ8
		ce && pins_f.reset_n && !pins_f.set_n |=> coil.oe == `ORDC_ALL_ON && shift_reg == `ORDC_ALL_ON)
		else $error("set input did not force every register to one");

	a_set_holds: assert property ( // RQ9
		ce && set_all ##1 ce && set_all |=> coil.oe == `ORDC_ALL_ON)
		else $error("interface activity turned an output off under set");

	a_deselect_hold: assert property ( // RQ15
		ce && normal && pins_f.cs_n && !cs_rise |=> $stable(shift_reg) && $stable(coil.oe))
		else $error("state changed while chip select was high");

	a_par_level: assert property ( // RQ11
		s_parallel_latch |=> coil.oe[$past(addr)] == $past(pins_f.level_select))
		else $error("addressed output did not take the level input");

	a_par_single: assert property ( // RQ12
		s_parallel_latch |=> ((coil.oe ^ $past(coil.oe)) & ~(8'h01 << $past(addr))) == `ORDC_ALL_OFF)
		else $error("parallel update touched an unaddressed output");

	a_par_idle: assert property ( // RQ16
		ce && normal && !serial_mode && !cs_rise |=> $stable(coil.oe))
		else $error("parallel outputs changed without chip select rise");

	a_drain_low: assert property ( // RQ18
		coil.out == `ORDC_DRAIN_LEVEL)
		else $error("open-drain data is not held low");

	a_shift_hold: assert property ( // RQ15
		ce && normal && serial_mode && !(selected && sclk_rise) |=> $stable(shift_reg))
		else $error("shift register moved without a selected rising shift clock");

	a_chain_deselect: assert property ( // RQ15
		ce && normal && !selected |=> $stable(chain_out))
		else $error("chain output moved while chip select was high");

	a_serial_latch_hold: assert property ( // RQ4
		s_normal_step ##0 serial_mode && !cs_rise |=> $stable(coil.oe))
		else $error("serial latch changed without chip select rise");

	a_par_no_shift: assert property ( // RQ16
		s_normal_step ##0 !serial_mode |=> $stable(shift_reg))
		else $error("parallel variant disturbed the shift register");

	a_par_chain_hold: assert property ( // RQ16
		s_normal_step ##0 !serial_mode |=> $stable(chain_out))
		else $error("parallel variant disturbed the chain output");

	a_set_chain_high: assert property ( // RQ8
		s_set_step |=> chain_out && coil.oe == `ORDC_ALL_ON)
		else $error("set input did not drive the chain output high");

	a_clear_over_set: assert property ( // RQ10
		s_clear_step ##0 !pins_f.set_n |=> coil.oe == `ORDC_ALL_OFF && !chain_out)
		else $error("set input beat the reset input");

	a_ce_freeze: assert property ( // RQ4
		!ce |=> $stable(shift_reg) && $stable(coil) && $stable(chain_out))
		else $error("state moved while the clock enable was low");
endmodule // ordc_top

// ---- testbench/ordc_host_model.sv ----
// Purpose: host model driving the relay driver pins
// Assumes: sys_clk 100 ns; shift clock period 800 ns
// Notes: shift clock idles low outside frames
`timescale 1ns/1ns
module ordc_host_model (
	input wire logic sys_clk,
	output ordc_pkg::ordc_pins_type pins,
	input wire logic chain_out
);
	import ordc_pkg::*;
	initial pins = 9'h103;
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// ==========
	// serial frame, select left low unless last
	task automatic ser(input logic [7:0] d, input bit last, output logic [7:0] q);
		pins.cs_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			pins.din = d[i];
			tick(4);
			pins.sclk = 1'b1;
			tick(4);
			q = {q[6:0], chain_out};
			pins.sclk = 1'b0;
		end
		tick(4);
		if (last) begin
			pins.cs_n = 1'b1;
			tick(6);
			pins.din = ~pins.din;
		end
	endtask
	task automatic noise();
		repeat (2) begin
			pins.sclk = 1'b1;
			pins.din = ~pins.din;
			tick(4);
			pins.sclk = 1'b0;
			tick(4);
		end
	endtask
	// ==========
	// parallel update and set/reset lines
	task automatic par(input logic [2:0] a, input logic l);
		{pins.addr_bit2, pins.addr_bit1, pins.addr_bit0} = a;
		pins.level_select = l;
		pins.cs_n = 1'b0;
		tick(6);
		pins.cs_n = 1'b1;
		tick(2);
		{pins.addr_bit2, pins.addr_bit1, pins.addr_bit0} = ~a;
		pins.level_select = ~l;
		tick(6);
	endtask
	task automatic lines(input logic s, input logic r);
		pins.set_n = s;
		pins.reset_n = r;
		tick(6);
	endtask
endmodule // ordc_host_model

// ---- testbench/ordc_tb.sv ----
// Purpose: self-checking bench of the relay driver control
// Assumes: host model drives every pin
// Notes: serial rows first, then edge, set/reset and parallel cases
`timescale 1ns/1ns
`include "ordc_consts.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module ordc_tb;
	import ordc_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	ordc_variant_type variant = ORDC_SERIAL;
	ordc_pins_type pins;
	ordc_coil_type coil;
	logic chain_out;
	int error_cnt = 0;
	int check_count = 0;
	logic [7:0] q;
	logic [7:0] prev = 8'h00;
	logic [7:0] exp_oe = 8'h00;
	logic [15:0] rows [4] = '{16'h8181, 16'h5a5a, 16'hffff, 16'h0101};
	always #50 sys_clk = ~sys_clk;
	ordc_top ordc_top_inst (.sys_clk(sys_clk), .rst(rst), .ce(ce), .variant(variant),
		.pins(pins), .coil(coil), .chain_out(chain_out));
	ordc_host_model ordc_host_model_inst (.sys_clk(sys_clk), .pins(pins), .chain_out(chain_out));
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		wrap_up();
	end
	// ==========
	// main sequence
	initial begin
		ordc_host_model_inst.tick(5);
		rst = 1'b0;
		ordc_host_model_inst.tick(2);
		`CHK(coil.oe, `ORDC_ALL_OFF)
		`CHK(chain_out, 1'b0)
		for (int i = 0; i < 4; i++) begin
			ordc_host_model_inst.ser(rows[i][15:8], 1'b1, q);
			`CHK(coil.oe, rows[i][7:0])
			`CHK(q, prev)
			`CHK(chain_out, rows[i][15])
			`CHK(coil.out, `ORDC_DRAIN_LEVEL)
			prev = rows[i][15:8];
		end
		$display("serial rows done");
		ordc_host_model_inst.noise();
		`CHK(coil.oe, prev)
		ce = 1'b0;
		ordc_host_model_inst.ser(8'ha5, 1'b1, q);
		ce = 1'b1;
		`CHK(coil.oe, prev)
		`CHK(chain_out, prev[7])
		ordc_host_model_inst.ser(8'h3c, 1'b0, q);
		`CHK(q, prev)
		`CHK(coil.oe, prev)
		ordc_host_model_inst.ser(8'hc3, 1'b1, q);
		`CHK(coil.oe, 8'hc3)
		`CHK(q, 8'h3c)
		$display("serial edge cases done");
		ordc_host_model_inst.lines(1'b0, 1'b1);
		`CHK(coil.oe, `ORDC_ALL_ON)
		`CHK(chain_out, 1'b1)
		ordc_host_model_inst.ser(8'h00, 1'b1, q);
		`CHK(coil.oe, `ORDC_ALL_ON)
		ordc_host_model_inst.lines(1'b0, 1'b0);
		`CHK(coil.oe, `ORDC_ALL_OFF)
		`CHK(chain_out, 1'b0)
		ordc_host_model_inst.lines(1'b1, 1'b0);
		`CHK(coil.oe, `ORDC_ALL_OFF)
		ordc_host_model_inst.lines(1'b1, 1'b1);
		$display("set and reset done");
		variant = ORDC_PARALLEL;
		rst = 1'b1;
		ordc_host_model_inst.tick(2);
		rst = 1'b0;
		for (int a = 0; a < 8; a++) begin
			ordc_host_model_inst.par(a[2:0], 1'b1);
			exp_oe[a] = 1'b1;
			`CHK(coil.oe, exp_oe)
		end
		ordc_host_model_inst.par(3'h5, 1'b0);
		exp_oe[5] = 1'b0;
		`CHK(coil.oe, exp_oe)
		$display("parallel done");
		wrap_up();
	end
endmodule // ordc_tb
